// ===== rsc_pkg.sv
// package: constants for the reset source control block
package rsc_pkg;

	// ****************************************************************
	// register bus layout
	// ****************************************************************
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 8;
	localparam logic [3:0]  ADDR_KEY        = 4'h0;
	localparam logic [3:0]  ADDR_FLAGS      = 4'h1;
	localparam logic [3:0]  ADDR_LEVEL      = 4'h2;
	localparam logic [3:0]  ADDR_PROG       = 4'h3;
	localparam logic [3:0]  ADDR_WDT        = 4'h4;
	localparam logic [3:0]  ADDR_STATUS     = 4'h5;
	localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h6;
	localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h7;

	// ****************************************************************
	// key codes and power-on values
	// ****************************************************************
	localparam logic [7:0]  KEY_CODE_A      = 8'h55;
	localparam logic [7:0]  KEY_CODE_B      = 8'haa;
	localparam logic [7:0]  KEY_RESET_VAL   = 8'h55;
	localparam logic [7:0]  LEVEL_RESET_VAL = 8'h55;
	localparam logic [7:0]  LEVEL_2V10      = 8'h55;
	localparam logic [7:0]  LEVEL_2V55      = 8'h33;
	localparam logic [7:0]  LEVEL_3V15      = 8'h99;
	localparam logic [7:0]  LEVEL_3V80      = 8'haa;
	localparam logic [7:0]  WDT_RESET_VAL   = 8'h53;
	localparam logic [4:0]  WDT_KEY_A       = 5'h0a;
	localparam logic [4:0]  WDT_KEY_B       = 5'h15;
	localparam logic [7:0]  PROG_RESET_CODE = 8'h55;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int          FLAG_KEY_POS    = 3;
	localparam int          FLAG_LV_POS     = 2;
	localparam int          FLAG_LEVEL_POS  = 1;
	localparam int          FLAG_WDT_POS    = 0;
	localparam int          WDT_KEY_LSB     = 3;
	localparam int          STAT_TO_POS     = 1;
	localparam int          STAT_PDF_POS    = 0;
	localparam int          IRQ_W           = 6;
	localparam int          IRQ_KEY_POS     = 0;
	localparam int          IRQ_LEVEL_POS   = 1;
	localparam int          IRQ_WDTKEY_POS  = 2;
	localparam int          IRQ_LV_POS      = 3;
	localparam int          IRQ_TIMEOUT_POS = 4;
	localparam int          IRQ_PROG_POS    = 5;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int          CLK_PERIOD_PS   = 5000;
	localparam int          SOFT_RESET_DELAY_NS = 80;
	localparam int          LV_QUALIFY_TIME_NS  = 100;
	localparam int          SOFT_RESET_CYCLES   =
		(SOFT_RESET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          LV_QUALIFY_CYCLES   =
		(LV_QUALIFY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int          CNT_W           = 8;

endpackage

// ===== rsc_reset_sync.sv
// reset release synchroniser
`timescale 1ns/1ps
module rsc_reset_sync
	import rsc_pkg::*;
(
	// clock and raw reset
	input  wire logic clk_sys,
	input  wire logic reset_n,
	// synchronised reset
	output logic      reset_sync_n
);

	typedef struct packed {
		logic stage1;
		logic stage2;
	} rsc_sync_s;

	rsc_sync_s state;
	rsc_sync_s next_state;

	always_comb begin
		next_state        = state;
		next_state.stage1 = 1'b1;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign reset_sync_n = state.stage2;

endmodule // rsc_reset_sync

// ===== rsc_qual_counter.sv
// restartable qualification counter with one-shot done pulse
`timescale 1ns/1ps
module rsc_qual_counter
	import rsc_pkg::*;
#(
	parameter int TARGET = 1
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// condition and result
	input  wire logic cond,
	output logic      done
);

	localparam logic [CNT_W-1:0] TGT   = CNT_W'(TARGET);
	localparam logic [CNT_W-1:0] TGT_1 = CNT_W'(TARGET - 1);

	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic             done;
	} rsc_cnt_s;

	rsc_cnt_s state;
	rsc_cnt_s next_state;

	// saturates at the target so a lasting condition fires once only
	always_comb begin
		next_state      = state;
		next_state.done = 1'b0;
		if (!cond) begin
			next_state.count = '0;
		end else if (state.count != TGT) begin
			next_state.count = state.count + 1'b1;
			next_state.done  = (state.count == TGT_1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign done = state.done;

endmodule // rsc_qual_counter

// ===== rsc_reset_source.sv
// reset source control: key checks, low-voltage qualify, cause flags
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps

// Contract
// - invalid reset key resets after delay
// - reset key powers up as 55h
// - key reset sets flag bit 3
// - flag bits 7..4 read zero
// - low-voltage watch off in sleep/idle
// - short low-supply episodes are ignored
// - qualified low-voltage reset sets bit 2
// - four level codes decode trip levels
// - bad level code resets, reloads level
// - low-voltage reset keeps level select
// - level select powers up as 55h
// - bad level code sets flag bit 1
// - 55h to programming register resets device
// - running time-out resets, sets time-out flag
// - sleep time-out clears pc and sp
// - bad watchdog key sets flag bit 0
// - power-on clears flags, sleep time-out sets
module rsc_reset_source
	import rsc_pkg::*;
(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// core and analogue side
	input  wire logic              sleep_idle,
	input  wire logic              low_supply,
	input  wire logic              wdt_timeout,
	// reset outputs
	output logic                   device_reset,
	output logic                   pc_sp_clear,
	output logic      [1:0]        trip_level_code,
	output logic                   low_voltage_enable,
	// interrupt
	output logic                   irq
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0]       reset_key_control;
		logic [3:0]       reset_cause_flags;
		logic [7:0]       low_voltage_level_select;
		logic [7:0]       watchdog_control_reg;
		logic             timeout_status_flag;
		logic             power_down_flag;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [7:0]       rdata;
		logic             device_reset;
		logic             pc_sp_clear;
		logic [1:0]       trip;
		logic             lv_enable;
		logic             irq;
	} rsc_state_s;

	rsc_state_s state;
	rsc_state_s next_state;

	logic rst_n;
	logic key_done;
	logic level_done;
	logic wdtkey_done;
	logic lv_done;
	logic key_bad;
	logic level_bad;
	logic wdtkey_bad;
	logic lv_watch;
	logic [2:0] level_dec;

	// ****************************************************************
	// decoding helpers
	// ****************************************************************
	function automatic logic key_ok(input logic [7:0] v);
		key_ok = (v == KEY_CODE_A) || (v == KEY_CODE_B);
	endfunction

	// bit 2 is valid, bits 1..0 the trip level index
	function automatic logic [2:0] level_decode(input logic [7:0] v);
		case (v)
			LEVEL_2V10: level_decode = 3'h4;
			LEVEL_2V55: level_decode = 3'h5;
			LEVEL_3V15: level_decode = 3'h6;
			LEVEL_3V80: level_decode = 3'h7;
			default:    level_decode = 3'h0;
		endcase
	endfunction

	function automatic logic wdt_key_ok(input logic [7:0] v);
		logic [4:0] k;
		k = v[WDT_KEY_LSB +: 5];
		wdt_key_ok = (k == WDT_KEY_A) || (k == WDT_KEY_B);
	endfunction

	// ****************************************************************
	// reset release and delay counters
	// ****************************************************************
	rsc_reset_sync u_sync (
		.clk_sys      (clk_sys),
		.reset_n      (reset_n),
		.reset_sync_n (rst_n)
	);

	assign key_bad    = !key_ok(state.reset_key_control);
	assign level_dec  = level_decode(state.low_voltage_level_select);
	assign level_bad  = !level_dec[2];
	assign wdtkey_bad = !wdt_key_ok(state.watchdog_control_reg);
	// monitoring only in running modes
	assign lv_watch   = low_supply && !sleep_idle;

	rsc_qual_counter #(
		.TARGET (SOFT_RESET_CYCLES)
	) u_key_delay (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.cond    (key_bad),
		.done    (key_done)
	);

	rsc_qual_counter #(
		.TARGET (SOFT_RESET_CYCLES)
	) u_level_delay (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.cond    (level_bad),
		.done    (level_done)
	);

	rsc_qual_counter #(
		.TARGET (SOFT_RESET_CYCLES)
	) u_wdtkey_delay (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.cond    (wdtkey_bad),
		.done    (wdtkey_done)
	);

	// a dip shorter than the qualify time restarts the count
	rsc_qual_counter #(
		.TARGET (LV_QUALIFY_CYCLES)
	) u_lv_qualify (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.cond    (lv_watch),
		.done    (lv_done)
	);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic             wr_key;
		logic             wr_flags;
		logic             wr_level;
		logic             wr_prog;
		logic             wr_wdt;
		logic             wr_mask;
		logic             rd_irq;
		logic             prog_reset;
		logic             run_timeout;
		logic             sleep_timeout;
		logic             soft_reset;
		logic             full_reset;
		logic [3:0]       flag_set;
		logic [IRQ_W-1:0] irq_set;
		logic [2:0]       lvl;

		wr_key        = reg_wr && (reg_addr == ADDR_KEY);
		wr_flags      = reg_wr && (reg_addr == ADDR_FLAGS);
		wr_level      = reg_wr && (reg_addr == ADDR_LEVEL);
		wr_prog       = reg_wr && (reg_addr == ADDR_PROG);
		wr_wdt        = reg_wr && (reg_addr == ADDR_WDT);
		wr_mask       = reg_wr && (reg_addr == ADDR_IRQ_MASK);
		rd_irq        = reg_rd && (reg_addr == ADDR_IRQ_STAT);
		prog_reset    = wr_prog && (reg_wdata == PROG_RESET_CODE);
		run_timeout   = wdt_timeout && !sleep_idle;
		sleep_timeout = wdt_timeout && sleep_idle;
		soft_reset    = key_done || level_done || wdtkey_done;
		full_reset    = soft_reset || lv_done || prog_reset
			|| run_timeout;
		flag_set      = '0;
		irq_set       = '0;
		lvl           = '0;

		next_state = state;

		// ************************************************************
		// cause flags: a write of zero clears, hardware set wins
		// ************************************************************
		flag_set[FLAG_KEY_POS]   = key_done;
		flag_set[FLAG_LV_POS]    = lv_done;
		flag_set[FLAG_LEVEL_POS] = level_done;
		flag_set[FLAG_WDT_POS]   = wdtkey_done;
		if (wr_flags) begin
			next_state.reset_cause_flags =
				state.reset_cause_flags & reg_wdata[3:0];
		end
		next_state.reset_cause_flags =
			next_state.reset_cause_flags | flag_set;

		// ************************************************************
		// software-written registers
		// ************************************************************
		if (wr_key) begin
			next_state.reset_key_control = reg_wdata;
		end
		if (wr_level) begin
			next_state.low_voltage_level_select = reg_wdata;
		end
		if (wr_wdt) begin
			next_state.watchdog_control_reg = reg_wdata;
		end
		if (wr_mask) begin
			next_state.irq_mask = reg_wdata[IRQ_W-1:0];
		end

		// ************************************************************
		// effects of a device reset on this block
		// ************************************************************
		if (full_reset) begin
			next_state.reset_key_control    = KEY_RESET_VAL;
			next_state.watchdog_control_reg = WDT_RESET_VAL;
		end
		// a pure low-voltage reset leaves the level select alone
		if (full_reset && !(lv_done && !soft_reset && !prog_reset
			&& !run_timeout)) begin
			next_state.low_voltage_level_select = LEVEL_RESET_VAL;
		end
		if (run_timeout) begin
			next_state.timeout_status_flag = 1'b1;
		end
		if (sleep_timeout) begin
			next_state.timeout_status_flag = 1'b1;
			next_state.power_down_flag     = 1'b1;
		end
		next_state.device_reset = full_reset;
		next_state.pc_sp_clear  = sleep_timeout;

		// ************************************************************
		// trip level to the comparator
		// ************************************************************
		lvl = level_decode(next_state.low_voltage_level_select);
		next_state.trip      = lvl[1:0];
		next_state.lv_enable = !sleep_idle;

		// ************************************************************
		// interrupt status: read clears, a new event wins
		// ************************************************************
		irq_set[IRQ_KEY_POS]     = key_done;
		irq_set[IRQ_LEVEL_POS]   = level_done;
		irq_set[IRQ_WDTKEY_POS]  = wdtkey_done;
		irq_set[IRQ_LV_POS]      = lv_done;
		irq_set[IRQ_TIMEOUT_POS] = wdt_timeout;
		irq_set[IRQ_PROG_POS]    = prog_reset;
		if (rd_irq) begin
			next_state.irq_status = irq_set;
		end else begin
			next_state.irq_status = state.irq_status | irq_set;
		end
		next_state.irq = |(next_state.irq_status & next_state.irq_mask);

		// ************************************************************
		// read data: valid only in the cycle after the strobe
		// ************************************************************
		next_state.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				ADDR_KEY: begin
					next_state.rdata = state.reset_key_control;
				end
				ADDR_FLAGS: begin
					next_state.rdata = {4'h0, state.reset_cause_flags};
				end
				ADDR_LEVEL: begin
					next_state.rdata = state.low_voltage_level_select;
				end
				ADDR_WDT: begin
					next_state.rdata = state.watchdog_control_reg;
				end
				ADDR_STATUS: begin
					next_state.rdata = {6'h00, state.timeout_status_flag,
						state.power_down_flag};
				end
				ADDR_IRQ_STAT: begin
					next_state.rdata = {2'h0, state.irq_status};
				end
				ADDR_IRQ_MASK: begin
					next_state.rdata = {2'h0, state.irq_mask};
				end
				// programming register is write-only
				default: begin
					next_state.rdata = 8'h00;
				end
			endcase
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state                          <= '0;
			state.reset_key_control        <= KEY_RESET_VAL;
			state.low_voltage_level_select <= LEVEL_RESET_VAL;
			state.watchdog_control_reg     <= WDT_RESET_VAL;
			state.trip                     <= 2'h0;
			state.lv_enable                <= 1'b0;
			state.timeout_status_flag      <= 1'b0;
			state.power_down_flag          <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign reg_rdata          = state.rdata;
	assign device_reset       = state.device_reset;
	assign pc_sp_clear        = state.pc_sp_clear;
	assign trip_level_code    = state.trip;
	assign low_voltage_enable = state.lv_enable;
	assign irq                = state.irq;

endmodule // rsc_reset_source

// ===== rsc_reset_source_sva.sv
// checker: port-level properties of the reset source control block
`timescale 1ns/1ps
module rsc_reset_source_sva
	import rsc_pkg::*;
(
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              reset_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// core and analogue side
	input wire logic              sleep_idle,
	input wire logic              low_supply,
	input wire logic              wdt_timeout,
	// results
	input wire logic              device_reset,
	input wire logic              pc_sp_clear,
	input wire logic [1:0]        trip_level_code,
	input wire logic              low_voltage_enable,
	input wire logic              irq
);
	// ****************************************************************
	// helper logic
	// ****************************************************************
	logic       key_bad;
	logic       lvl_bad;
	logic [7:0] lv_run;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	assign key_bad = reg_wr && reg_addr == ADDR_KEY &&
		reg_wdata != KEY_CODE_A && reg_wdata != KEY_CODE_B;
	assign lvl_bad = reg_wr && reg_addr == ADDR_LEVEL &&
		reg_wdata != LEVEL_2V10 && reg_wdata != LEVEL_2V55 &&
		reg_wdata != LEVEL_3V15 && reg_wdata != LEVEL_3V80;

	// consecutive cycles of an unmasked low supply, saturating
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n)
			lv_run <= 8'h00;
		else if (!(low_supply && !sleep_idle))
			lv_run <= 8'h00;
		else if (lv_run != 8'hff)
			lv_run <= lv_run + 8'h01;
	end

	// ****************************************************************
	// properties
	// ****************************************************************
	a_key_bad_delay: assert property (key_bad |=>
		!device_reset [*8] ##[8:10] device_reset)
		else $error("bad key write not followed by delayed reset");
	a_level_bad_delay: assert property (lvl_bad |=>
		!device_reset [*8] ##[8:10] device_reset)
		else $error("bad level write not followed by delayed reset");
	a_prog_reset_now: assert property (reg_wr &&
		reg_addr == ADDR_PROG && reg_wdata == PROG_RESET_CODE |=> device_reset)
		else $error("programming code did not reset");
	a_run_timeout_reset: assert property (wdt_timeout && !sleep_idle
		|=> device_reset && !pc_sp_clear)
		else $error("running time-out did not reset");
	a_sleep_timeout_clear: assert property (wdt_timeout && sleep_idle
		|=> pc_sp_clear && !device_reset)
		else $error("sleep time-out wrong response");
	a_lv_sleep_off: assert property (sleep_idle |=>
		!low_voltage_enable)
		else $error("low-voltage watch on in sleep");
	a_lv_qualify_fire: assert property (lv_run == LV_QUALIFY_CYCLES
		|-> ##[0:2] device_reset)
		else $error("qualified low supply did not reset");
	a_flags_top_zero: assert property (reg_rd &&
		reg_addr == ADDR_FLAGS |=> reg_rdata[7:4] == 4'h0)
		else $error("flag register top bits not zero");
	a_trip_decode: assert property (reg_wr &&
		reg_addr == ADDR_LEVEL && reg_wdata == LEVEL_3V15
		|-> ##[1:2] trip_level_code == 2'h2)
		else $error("trip level decode wrong");
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");
	a_irq_masked: assert property (reg_wr && reg_addr == ADDR_IRQ_MASK &&
		reg_wdata == 8'h00 |-> ##2 !irq)
		else $error("irq high with mask cleared");
endmodule // rsc_reset_source_sva

bind rsc_reset_source rsc_reset_source_sva u_sva (
	.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .sleep_idle(sleep_idle),
	.low_supply(low_supply), .wdt_timeout(wdt_timeout),
	.device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
	.trip_level_code(trip_level_code),
	.low_voltage_enable(low_voltage_enable), .irq(irq));

// ===== tb.sv
// testbench: directed scenarios for the reset source control block
`timescale 1ns/1ps
module tb
	import rsc_pkg::*;
;
	logic       clk_sys = 1'b0, reset_n = 1'b0;
	logic       reg_wr = 1'b0, reg_rd = 1'b0;
	logic       sleep_idle = 1'b0, low_supply = 1'b0, wdt_timeout = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic       device_reset, pc_sp_clear, low_voltage_enable, irq;
	logic [1:0] trip_level_code;
	int         mismatches = 0, checks = 0, cycles = 0, n;
	localparam logic [7:0] LVL [4] = '{LEVEL_2V10, LEVEL_2V55,
		LEVEL_3V15, LEVEL_3V80};

	always #2.5 clk_sys = ~clk_sys;

	rsc_reset_source DUT (.clk_sys(clk_sys), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_idle(sleep_idle),
		.low_supply(low_supply), .wdt_timeout(wdt_timeout),
		.device_reset(device_reset), .pc_sp_clear(pc_sp_clear),
		.trip_level_code(trip_level_code),
		.low_voltage_enable(low_voltage_enable), .irq(irq));

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task conclude;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// reset delay figures allow one cycle either way
	task near(input string nm, input int got, input int exp);
		chk(nm, {7'h0, got >= exp - 1 && got <= exp + 1}, 8'h01);
	endtask

	// idle cycle after the strobe so writes never meet at one edge
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(nm, reg_rdata, exp);
		@(posedge clk_sys);
	endtask

	// cycles until device_reset is seen, 0 if never within hi
	task run(input int hi, output int k);
		k = 0;
		for (int i = 1; i <= hi && k == 0; i++) begin
			@(negedge clk_sys);
			if (device_reset === 1'b1)
				k = i;
		end
		@(posedge clk_sys);
	endtask

	task irq_is(input logic e);
		@(negedge clk_sys);
		chk("irq", {7'h0, irq}, {7'h0, e});
		@(posedge clk_sys);
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_por;
		rd(ADDR_KEY, KEY_RESET_VAL, "key por");
		rd(ADDR_LEVEL, LEVEL_RESET_VAL, "level por");
		rd(ADDR_FLAGS, 8'h00, "flags por");
		rd(ADDR_STATUS, 8'h00, "status por");
		rd(4'hf, 8'h00, "unmapped read");
		chk("trip por", {6'h0, trip_level_code}, 8'h00);
	endtask

	task t_prog_irq;
		rd(ADDR_IRQ_STAT, 8'h00, "irq status por");
		wr(ADDR_PROG, 8'h54);
		run(20, n);
		chk("prog other", 8'(n), 8'h00);
		// inline write: the one-cycle reset pulse stands in the idle cycle
		reg_addr <= ADDR_PROG;
		reg_wdata <= PROG_RESET_CODE;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		run(5, n);
		chk("prog delay", 8'(n), 8'h01);
		irq_is(1'b0);
		wr(ADDR_IRQ_MASK, 8'h20);
		irq_is(1'b1);
		wr(ADDR_IRQ_MASK, 8'h00);
		irq_is(1'b0);
		wr(ADDR_IRQ_MASK, 8'h20);
		rd(ADDR_IRQ_STAT, 8'h20, "irq status");
		irq_is(1'b0);
		wr(ADDR_IRQ_MASK, 8'h00);
	endtask

	task t_key;
		wr(ADDR_KEY, KEY_CODE_B);
		run(30, n);
		chk("valid key", 8'(n), 8'h00);
		rd(ADDR_KEY, KEY_CODE_B, "key readback");
		wr(ADDR_KEY, 8'h54);
		run(30, n);
		near("key delay", n, SOFT_RESET_CYCLES + 1);
		rd(ADDR_KEY, KEY_RESET_VAL, "key reload");
		rd(ADDR_FLAGS, 8'h08, "key flag");
		wr(ADDR_FLAGS, 8'hff);
		rd(ADDR_FLAGS, 8'h08, "key flag kept");
		wr(ADDR_FLAGS, 8'h00);
		rd(ADDR_FLAGS, 8'h00, "key flag clear");
	endtask

	task t_level;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LEVEL, LVL[i]);
			run(20, n);
			chk("valid level", 8'(n), 8'h00);
			chk("trip code", {6'h0, trip_level_code}, 8'(i));
		end
		wr(ADDR_LEVEL, 8'h3c);
		run(30, n);
		near("level delay", n, SOFT_RESET_CYCLES + 1);
		rd(ADDR_LEVEL, LEVEL_RESET_VAL, "level reload");
		rd(ADDR_FLAGS, 8'h02, "level flag");
		wr(ADDR_FLAGS, 8'h00);
	endtask

	task t_low_voltage;
		wr(ADDR_LEVEL, LEVEL_3V80);
		for (int i = 0; i < 2; i++) begin
			low_supply <= 1'b1;
			run(LV_QUALIFY_CYCLES - 4, n);
			low_supply <= 1'b0;
			chk("short dip", 8'(n), 8'h00);
			@(posedge clk_sys);
		end
		sleep_idle <= 1'b1;
		@(posedge clk_sys);
		low_supply <= 1'b1;
		run(40, n);
		chk("sleep dip", 8'(n), 8'h00);
		chk("watch off", {7'h0, low_voltage_enable}, 8'h00);
		sleep_idle <= 1'b0;
		run(40, n);
		low_supply <= 1'b0;
		near("lv delay", n, LV_QUALIFY_CYCLES + 2);
		chk("watch on", {7'h0, low_voltage_enable}, 8'h01);
		rd(ADDR_FLAGS, 8'h04, "lv flag");
		rd(ADDR_LEVEL, LEVEL_3V80, "level kept");
		wr(ADDR_FLAGS, 8'h00);
	endtask

	task t_watchdog;
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		run(5, n);
		chk("run timeout", 8'(n), 8'h01);
		rd(ADDR_STATUS, 8'h02, "status run");
		wr(ADDR_KEY, KEY_CODE_B);
		sleep_idle <= 1'b1;
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		@(negedge clk_sys);
		chk("pc sp clear", {pc_sp_clear, device_reset}, 8'h02);
		@(posedge clk_sys);
		sleep_idle <= 1'b0;
		rd(ADDR_STATUS, 8'h03, "status sleep");
		rd(ADDR_KEY, KEY_CODE_B, "key kept");
		wr(ADDR_WDT, 8'h00);
		run(30, n);
		near("wdt key delay", n, SOFT_RESET_CYCLES + 1);
		rd(ADDR_FLAGS, 8'h01, "wdt flag");
		rd(ADDR_WDT, WDT_RESET_VAL, "wdt reload");
	endtask

	// ****************************************************************
	// main sequence and watchdog on the run
	// ****************************************************************
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			conclude;
		end
	end

	initial begin
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		t_por;
		t_prog_irq;
		t_key;
		t_level;
		t_low_voltage;
		t_watchdog;
		conclude;
	end
endmodule // tb
